// ===== hw/rpwr_cfg.svh
`ifndef RPWR_CFG_SVH
`define RPWR_CFG_SVH

// Register indices on the software port
`define RPWR_REG_CTRL       4'h0
`define RPWR_REG_GUIDE_S    4'h1
`define RPWR_REG_GUIDE_L    4'h2
`define RPWR_REG_LOW_S      4'h3
`define RPWR_REG_LOW_L      4'h4
`define RPWR_REG_ZERO_S     4'h5
`define RPWR_REG_ZERO_L     4'h6
`define RPWR_REG_ONE_S      4'h7
`define RPWR_REG_ONE_L      4'h8
`define RPWR_REG_END_W      4'h9
`define RPWR_REG_SHIFT      4'ha
`define RPWR_REG_COUNT      4'hb
`define RPWR_REG_DATA       4'hc
`define RPWR_REG_STATUS     4'hd

// Control register fields
`define RPWR_CTRL_EN        7
`define RPWR_CTRL_NCW       6
`define RPWR_CTRL_HALVE     5
`define RPWR_CTRL_MASK      8'he0

// Reset values
`define RPWR_RST_BYTE       8'h00
`define RPWR_RST_CNT        4'h0

// Widths and counts
`define RPWR_DATA_BITS      8
`define RPWR_WORD_BITS      4'h8
`define RPWR_CNT_MAX        8'hff

`endif

// ===== hw/rpwr_pkg.sv
package rpwr_pkg;

   typedef enum logic [2:0] {
      RPWR_IDLE      = 3'b000,
      RPWR_WAIT_RISE = 3'b001,
      RPWR_GUIDE_HI  = 3'b010,
      RPWR_DATA_LO   = 3'b011,
      RPWR_DATA_HI   = 3'b100,
      RPWR_END_LO    = 3'b101,
      RPWR_HALT      = 3'b110
   } rpwr_state_t;

   typedef struct packed {
      logic reception_error_event;
      logic reception_end_event;
      logic guide_pulse_event;
      logic data_full_event;
   } rpwr_events_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rpwr_bus_req_t;

endpackage : rpwr_pkg

// ===== hw/rpwr_receiver.sv
// Functional notes
// - Zero-width high records bit 0, measures low
// - One-width high records bit 1, measures low
// - Short or gap high width gives error
// - High reaching one-long threshold gives error
// - Rise during end count gives error
// - End count done raises end, halts
// - Rise before data-low short gives error
// - No error before valid guide pulse
// - One error only until next guide
// - End count starts after data-low long passed
// - Operation tick is source or halved source
// - Pin synchronised, first stage one tick later
// - Second stage follows first when agreeing
// - Third stage follows second when agreeing
// - Noise bit selects second or third stage
// - Filter rejects short pulses per setting
// - Internal input lags pin by stages
// - Valid guide width raises guide, starts data
// - Long data low starts end count
// - Full shift register copies to data, clears
// - Error clears shift register and bit count
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "rpwr_cfg.svh"

module rpwr_receiver (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Source clock enable and remote pin
   input wire logic src_tick,
   input wire logic remote_input_pin,
   // Software register port
   input wire rpwr_pkg::rpwr_bus_req_t bus_req,
   output logic [7:0] rdata,
   // Event pulses
   output rpwr_pkg::rpwr_events_t events
);
   import rpwr_pkg::*;

   logic rst_pipe;
   logic rst_n;
   logic [7:0] ctrl;
   logic [7:0] guide_high_short_threshold;
   logic [7:0] guide_high_long_threshold;
   logic [7:0] data_low_short_threshold;
   logic [7:0] data_low_long_threshold;
   logic [7:0] zero_high_short_threshold;
   logic [7:0] zero_high_long_threshold;
   logic [7:0] one_high_short_threshold;
   logic [7:0] one_high_long_threshold;
   logic [7:0] end_width_threshold;
   logic [7:0] receive_shift_register;
   logic [3:0] received_bit_count;
   logic [7:0] receive_data_register;
   logic half_phase;
   logic op_tick;
   logic sync_in;
   logic sample_stage_one;
   logic sample_stage_two;
   logic sample_stage_three;
   logic filt_in;
   logic filt_prev;
   logic rise;
   logic fall;
   logic [7:0] width_cnt;
   rpwr_state_t state;
   rpwr_state_t next_state;
   logic err_lock;
   logic err_hit;
   logic bit_valid;
   logic bit_value;
   logic guide_ok;
   logic end_hit;
   logic shift_read;
   logic receive_enable_bit;
   logic noise_width_bit;
   logic clock_halve_bit;

   function automatic logic in_range(input logic [7:0] v,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (v >= lo) && (v < hi);
   endfunction : in_range

   // Reset release through two flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_pipe <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_pipe <= 1'b1;
         rst_n <= rst_pipe;
      end
   end

   assign receive_enable_bit = ctrl[`RPWR_CTRL_EN];
   assign noise_width_bit = ctrl[`RPWR_CTRL_NCW];
   assign clock_halve_bit = ctrl[`RPWR_CTRL_HALVE];
   assign shift_read = bus_req.rd && (bus_req.addr == `RPWR_REG_SHIFT);

   // Thresholds and control; thresholds are taken as written, control keeps bits 7 to 5 only;
   // software keeps them stable and ordered while the receiver runs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `RPWR_RST_BYTE;
         guide_high_short_threshold <= `RPWR_RST_BYTE;
         guide_high_long_threshold <= `RPWR_RST_BYTE;
         data_low_short_threshold <= `RPWR_RST_BYTE;
         data_low_long_threshold <= `RPWR_RST_BYTE;
         zero_high_short_threshold <= `RPWR_RST_BYTE;
         zero_high_long_threshold <= `RPWR_RST_BYTE;
         one_high_short_threshold <= `RPWR_RST_BYTE;
         one_high_long_threshold <= `RPWR_RST_BYTE;
         end_width_threshold <= `RPWR_RST_BYTE;
      end else if (bus_req.wr) begin
         if (bus_req.addr == `RPWR_REG_CTRL) begin
            ctrl <= bus_req.wdata & `RPWR_CTRL_MASK;
         end else if (bus_req.addr == `RPWR_REG_GUIDE_S) begin
            guide_high_short_threshold <= bus_req.wdata;
         end else if (bus_req.addr == `RPWR_REG_GUIDE_L) begin
            guide_high_long_threshold <= bus_req.wdata;
         end else if (bus_req.addr == `RPWR_REG_LOW_S) begin
            data_low_short_threshold <= bus_req.wdata;
         end else if (bus_req.addr == `RPWR_REG_LOW_L) begin
            data_low_long_threshold <= bus_req.wdata;
         end else if (bus_req.addr == `RPWR_REG_ZERO_S) begin
            zero_high_short_threshold <= bus_req.wdata;
         end else if (bus_req.addr == `RPWR_REG_ZERO_L) begin
            zero_high_long_threshold <= bus_req.wdata;
         end else if (bus_req.addr == `RPWR_REG_ONE_S) begin
            one_high_short_threshold <= bus_req.wdata;
         end else if (bus_req.addr == `RPWR_REG_ONE_L) begin
            one_high_long_threshold <= bus_req.wdata;
         end else if (bus_req.addr == `RPWR_REG_END_W) begin
            end_width_threshold <= bus_req.wdata;
         end
      end
   end

   // Operation tick: every source tick, or every second one when halved
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         half_phase <= 1'b0;
      end else if (!receive_enable_bit) begin
         half_phase <= 1'b0;
      end else if (src_tick) begin
         half_phase <= ~half_phase;
      end
   end

   assign op_tick = src_tick && receive_enable_bit
                    && (!clock_halve_bit || half_phase);

   // Noise filter: stages two and three only move when the synchronised level agrees,
   // so one stray tick of the other level never reaches the decoder
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync_in <= 1'b0;
         sample_stage_one <= 1'b0;
         sample_stage_two <= 1'b0;
         sample_stage_three <= 1'b0;
         filt_prev <= 1'b0;
      end else if (!receive_enable_bit) begin
         sync_in <= 1'b0;
         sample_stage_one <= 1'b0;
         sample_stage_two <= 1'b0;
         sample_stage_three <= 1'b0;
         filt_prev <= 1'b0;
      end else if (op_tick) begin
         sync_in <= remote_input_pin;
         sample_stage_one <= sync_in;
         if (sync_in == sample_stage_one) begin
            sample_stage_two <= sample_stage_one;
         end
         if (sync_in == sample_stage_two) begin
            sample_stage_three <= sample_stage_two;
         end
         filt_prev <= filt_in;
      end
   end

   assign filt_in = noise_width_bit ? sample_stage_three
                                    : sample_stage_two;
   assign rise = op_tick && filt_in && !filt_prev;
   assign fall = op_tick && !filt_in && filt_prev;

   // Single width counter, restarted on every filtered edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         width_cnt <= `RPWR_RST_BYTE;
      end else if (state == RPWR_IDLE) begin
         width_cnt <= `RPWR_RST_BYTE;
      end else if (rise || fall) begin
         width_cnt <= `RPWR_RST_BYTE;
      end else if (op_tick && state == RPWR_DATA_LO
                   && width_cnt == data_low_long_threshold) begin
         width_cnt <= `RPWR_RST_BYTE;
      end else if (op_tick && width_cnt != `RPWR_CNT_MAX) begin
         width_cnt <= width_cnt + 8'h01;
      end
   end

   assign guide_ok = in_range(width_cnt, guide_high_short_threshold,
                              guide_high_long_threshold);
   assign end_hit = op_tick && !filt_in
                    && width_cnt == end_width_threshold;

   // Phase decisions
   always_comb begin
      next_state = state;
      err_hit = 1'b0;
      bit_valid = 1'b0;
      bit_value = 1'b0;
      if (!receive_enable_bit) begin
         next_state = RPWR_IDLE;
      end else begin
         case (state)
            RPWR_IDLE: begin
               next_state = RPWR_WAIT_RISE;
            end
            RPWR_WAIT_RISE: begin
               if (rise) begin
                  next_state = RPWR_GUIDE_HI;
               end
            end
            RPWR_GUIDE_HI: begin
               if (fall) begin
                  next_state = guide_ok ? RPWR_DATA_LO
                                        : RPWR_WAIT_RISE;
               end
            end
            RPWR_DATA_LO: begin
               if (rise) begin
                  if (width_cnt < data_low_short_threshold) begin
                     err_hit = 1'b1;
                     next_state = RPWR_GUIDE_HI;
                  end else begin
                     next_state = RPWR_DATA_HI;
                  end
               end else if (op_tick
                            && width_cnt == data_low_long_threshold) begin
                  next_state = RPWR_END_LO;
               end
            end
            RPWR_DATA_HI: begin
               if (fall) begin
                  if (in_range(width_cnt, zero_high_short_threshold,
                               zero_high_long_threshold)) begin
                     bit_valid = 1'b1;
                     next_state = RPWR_DATA_LO;
                  end else if (in_range(width_cnt, one_high_short_threshold,
                                        one_high_long_threshold)) begin
                     bit_valid = 1'b1;
                     bit_value = 1'b1;
                     next_state = RPWR_DATA_LO;
                  end else begin
                     err_hit = 1'b1;
                     next_state = RPWR_WAIT_RISE;
                  end
               end else if (op_tick && filt_in
                            && width_cnt >= one_high_long_threshold) begin
                  err_hit = 1'b1;
                  next_state = RPWR_WAIT_RISE;
               end
            end
            RPWR_END_LO: begin
               if (rise) begin
                  err_hit = 1'b1;
                  next_state = RPWR_GUIDE_HI;
               end else if (end_hit) begin
                  next_state = RPWR_HALT;
               end
            end
            RPWR_HALT: begin
               if (shift_read) begin
                  next_state = RPWR_WAIT_RISE;
               end
            end
            default: begin
               next_state = RPWR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= RPWR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Error lock: cleared by a valid guide, set by the first error after it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         err_lock <= 1'b1;
      end else if (state == RPWR_IDLE) begin
         err_lock <= 1'b1;
      end else if (state == RPWR_GUIDE_HI && fall && guide_ok) begin
         err_lock <= 1'b0;
      end else if (err_hit) begin
         err_lock <= 1'b1;
      end
   end

   // Shift register, bit count and data register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         receive_shift_register <= `RPWR_RST_BYTE;
         received_bit_count <= `RPWR_RST_CNT;
         receive_data_register <= `RPWR_RST_BYTE;
      end else if (!receive_enable_bit) begin
         receive_shift_register <= `RPWR_RST_BYTE;
         received_bit_count <= `RPWR_RST_CNT;
         receive_data_register <= `RPWR_RST_BYTE;
      end else if (err_hit || (state == RPWR_HALT && shift_read)) begin
         receive_shift_register <= `RPWR_RST_BYTE;
         received_bit_count <= `RPWR_RST_CNT;
      end else if (bit_valid) begin
         // Bits arrive first into the top and move down
         if (received_bit_count == `RPWR_WORD_BITS - 4'h1) begin
            receive_data_register <= {bit_value,
                                      receive_shift_register[7:1]};
            receive_shift_register <= `RPWR_RST_BYTE;
            received_bit_count <= `RPWR_RST_CNT;
         end else begin
            receive_shift_register <= {bit_value,
                                       receive_shift_register[7:1]};
            received_bit_count <= received_bit_count + 4'h1;
         end
      end
   end

   // Event pulses, one mclk cycle each
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         events <= '0;
      end else begin
         events.reception_error_event <= err_hit && !err_lock;
         events.reception_end_event <= state == RPWR_END_LO
                                       && !rise && end_hit;
         events.guide_pulse_event <= state == RPWR_GUIDE_HI
                                     && fall && guide_ok;
         events.data_full_event <= bit_valid && !err_hit
            && received_bit_count == `RPWR_WORD_BITS - 4'h1;
      end
   end

   // Read port: data stand only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= `RPWR_RST_BYTE;
      end else if (!bus_req.rd) begin
         rdata <= `RPWR_RST_BYTE;
      end else if (bus_req.addr == `RPWR_REG_CTRL) begin
         rdata <= ctrl;
      end else if (bus_req.addr == `RPWR_REG_GUIDE_S) begin
         rdata <= guide_high_short_threshold;
      end else if (bus_req.addr == `RPWR_REG_GUIDE_L) begin
         rdata <= guide_high_long_threshold;
      end else if (bus_req.addr == `RPWR_REG_LOW_S) begin
         rdata <= data_low_short_threshold;
      end else if (bus_req.addr == `RPWR_REG_LOW_L) begin
         rdata <= data_low_long_threshold;
      end else if (bus_req.addr == `RPWR_REG_ZERO_S) begin
         rdata <= zero_high_short_threshold;
      end else if (bus_req.addr == `RPWR_REG_ZERO_L) begin
         rdata <= zero_high_long_threshold;
      end else if (bus_req.addr == `RPWR_REG_ONE_S) begin
         rdata <= one_high_short_threshold;
      end else if (bus_req.addr == `RPWR_REG_ONE_L) begin
         rdata <= one_high_long_threshold;
      end else if (bus_req.addr == `RPWR_REG_END_W) begin
         rdata <= end_width_threshold;
      end else if (bus_req.addr == `RPWR_REG_SHIFT) begin
         rdata <= receive_shift_register;
      end else if (bus_req.addr == `RPWR_REG_COUNT) begin
         rdata <= {4'h0, received_bit_count};
      end else if (bus_req.addr == `RPWR_REG_DATA) begin
         rdata <= receive_data_register;
      end else if (bus_req.addr == `RPWR_REG_STATUS) begin
         rdata <= {3'h0, err_lock, filt_in, state};
      end else begin
         rdata <= `RPWR_RST_BYTE;
      end
   end

endmodule : rpwr_receiver

// ===== verif/rpwr_receiver_props.sv
`timescale 1ns/10ps
`include "rpwr_cfg.svh"

module rpwr_receiver_props (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Watched ports
   input wire logic src_tick,
   input wire logic remote_input_pin,
   input wire rpwr_pkg::rpwr_bus_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire rpwr_pkg::rpwr_events_t events
);
   import rpwr_pkg::*;
   logic armed;
   logic halted;
   logic enabled;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence s_end_ev;
      events.reception_end_event;
   endsequence

   // Armed from a good guide until the next error
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) armed <= 1'b0;
      else if (events.reception_error_event) armed <= 1'b0;
      else if (events.guide_pulse_event) armed <= 1'b1;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) halted <= 1'b0;
      else if (events.reception_end_event) halted <= 1'b1;
      else if (bus_req.rd && bus_req.addr == `RPWR_REG_SHIFT) halted <= 1'b0;
      else if (bus_req.wr && bus_req.addr == `RPWR_REG_CTRL) halted <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) enabled <= 1'b0;
      else if (bus_req.wr && bus_req.addr == `RPWR_REG_CTRL) begin
         enabled <= bus_req.wdata[`RPWR_CTRL_EN];
      end
   end

   a_rdata_after_read: assert property (
      !$past(bus_req.rd) |-> rdata == 8'h00)
      else $error("read data outside the answer cycle");
   a_error_needs_guide: assert property (
      events.reception_error_event |-> armed)
      else $error("error event without a fresh guide");
   a_full_needs_guide: assert property (
      events.data_full_event |-> armed)
      else $error("data full without a guide");
   a_end_needs_guide: assert property (
      s_end_ev |-> armed && !events.reception_error_event)
      else $error("end event without a guide");
   a_event_on_tick: assert property (
      events != 4'h0 |-> $past(src_tick))
      else $error("event not one cycle after a tick");
   a_end_halts: assert property (
      s_end_ev |=> (events == 4'h0) [*8])
      else $error("event right after end");
   a_halt_quiet: assert property (
      halted |-> events == 4'h0)
      else $error("event while halted");
   a_quiet_disabled: assert property (
      !enabled && !$past(enabled) |-> events == 4'h0)
      else $error("event while disabled");
   a_error_pulse: assert property (
      events.reception_error_event |=> !events.reception_error_event)
      else $error("error event longer than one cycle");
endmodule : rpwr_receiver_props

bind rpwr_receiver rpwr_receiver_props rpwr_receiver_props_i (
   .mclk(mclk),
   .rstn(rstn),
   .src_tick(src_tick),
   .remote_input_pin(remote_input_pin),
   .bus_req(bus_req),
   .rdata(rdata),
   .events(events)
);

// ===== verif/rpwr_remote.sv
`timescale 1ns/10ps

module rpwr_remote (
   // Clock and source ticks
   input wire logic mclk,
   input wire logic src_tick,
   // Remote pin
   output logic remote_input_pin
);
   initial remote_input_pin = 1'b0;

   // Caller sits just after a rising edge; widths are in source ticks
   task automatic drive(input logic lvl, input int n);
      remote_input_pin <= lvl;
      repeat (n) @(posedge mclk iff src_tick);
   endtask : drive

   // Guide with an optional glitch, eight bits first bit first, long low
   task automatic frame(input logic [7:0] b, input int h, input int g);
      drive(1'b1, 4 * h);
      if (g != 0) drive(1'b0, g);
      drive(1'b1, 6 * h - g);
      for (int i = 0; i < 8; i++) begin
         drive(1'b0, 5 * h);
         drive(1'b1, b[i] ? 8 * h : 4 * h);
      end
      drive(1'b0, 30 * h);
   endtask : frame
endmodule : rpwr_remote

// ===== verif/tb.sv
`timescale 1ns/10ps
`include "rpwr_cfg.svh"

module tb;
   import rpwr_pkg::*;
   localparam logic [3:0] EV_ERR = 4'h8;
   localparam logic [3:0] EV_END = 4'h4;
   localparam logic [3:0] EV_GP = 4'h2;
   localparam logic [3:0] EV_FULL = 4'h1;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic src_tick = 1'b0;
   logic [1:0] tick_cnt = 2'h0;
   rpwr_bus_req_t bus_req = '0;
   logic [7:0] rdata;
   rpwr_events_t events;
   logic remote_input_pin;
   logic [3:0] ev_q[$];
   logic [7:0] rd_q[$];
   logic rd_seen = 1'b0;
   logic [31:0] seed = 32'h3f61f163;
   logic [7:0] thr [1:9] = '{8'h08, 8'h0c, 8'h03, 8'h08, 8'h02, 8'h05,
                             8'h06, 8'h09, 8'h04};
   int glitch [4] = '{0, 1, 1, 3};
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;

   always #2.5 mclk = ~mclk;

   always @(posedge mclk) begin
      tick_cnt <= tick_cnt + 2'h1;
      src_tick <= tick_cnt == 2'h3;
   end

   rpwr_receiver rpwr_receiver_i (
      .mclk(mclk),
      .rstn(rstn),
      .src_tick(src_tick),
      .remote_input_pin(remote_input_pin),
      .bus_req(bus_req),
      .rdata(rdata),
      .events(events)
   );

   rpwr_remote rpwr_remote_i (
      .mclk(mclk),
      .src_tick(src_tick),
      .remote_input_pin(remote_input_pin)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   // A gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      @(posedge mclk);
   endtask : rd

   // Good guide, then a broken data phase that ends in one error
   task automatic guide_err(input int lo, input int hi, input int lo2);
      ev_q.push_back(EV_GP);
      ev_q.push_back(EV_ERR);
      rpwr_remote_i.drive(1'b1, 10);
      rpwr_remote_i.drive(1'b0, lo);
      if (hi != 0) begin
         rpwr_remote_i.drive(1'b1, hi);
         rpwr_remote_i.drive(1'b0, lo2);
      end
   endtask : guide_err

   // Any event with no note pending is a mismatch
   always @(negedge mclk) begin
      if (rd_seen) check(rdata, rd_q.pop_front());
      rd_seen = bus_req.rd;
      if (events !== 4'h0) begin
         if (ev_q.size() == 0) check({4'h0, events}, 8'h00);
         else check({4'h0, events}, {4'h0, ev_q.pop_front()});
      end
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      logic [7:0] b;
      logic [7:0] m;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      for (int i = 1; i <= 9; i++) wr(4'(i), thr[i]);
      for (int i = 1; i <= 9; i++) rd(4'(i), thr[i]);
      wr(`RPWR_REG_CTRL, 8'h1f);
      rd(`RPWR_REG_CTRL, 8'h00);
      wr(4'he, 8'h5a);
      rd(4'he, 8'h00);
      for (int k = 0; k < 4; k++) begin
         m = 8'(k) << 5;
         seed = lfsr(seed);
         b = seed[7:0];
         wr(`RPWR_REG_CTRL, m);
         wr(`RPWR_REG_CTRL, 8'h80 | m);
         ev_q.push_back(EV_GP);
         ev_q.push_back(EV_FULL);
         ev_q.push_back(EV_END);
         rpwr_remote_i.frame(b, k[0] ? 2 : 1, glitch[k]);
         rd(`RPWR_REG_DATA, b);
         rd(`RPWR_REG_COUNT, 8'h00);
         rd(`RPWR_REG_SHIFT, 8'h00);
         wr(`RPWR_REG_CTRL, m);
      end
      wr(`RPWR_REG_CTRL, 8'h80);
      rpwr_remote_i.drive(1'b1, 3);
      rpwr_remote_i.drive(1'b0, 12);
      guide_err(2, 0, 0);
      guide_err(5, 2, 12);
      guide_err(5, 6, 12);
      guide_err(5, 14, 12);
      guide_err(5, 8, 11);
      rpwr_remote_i.drive(1'b1, 3);
      rpwr_remote_i.drive(1'b0, 12);
      rd(`RPWR_REG_COUNT, 8'h00);
      rd(`RPWR_REG_SHIFT, 8'h00);
      rd(`RPWR_REG_STATUS, 8'h11);
      repeat (20) @(posedge mclk);
      check(8'(ev_q.size()), 8'h00);
      final_report();
   end
endmodule : tb
